// ### hw/nfo_pkg.sv
/*
  Constants and types for the NAND auxiliary-function host controller.
  Assumes a 100 MHz clock and an asynchronous 8-bit NAND bus on the far side.
*/
package nfo_pkg;
  // ==========================================================
  // NAND commands
  localparam logic [7:0] CMD_READ0 = 8'h00;
  localparam logic [7:0] CMD_PROG0 = 8'h80;
  localparam logic [7:0] CMD_PROG1 = 8'h10;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_UID = 8'hed;
  localparam logic [7:0] CMD_SET_FEAT = 8'hef;
  localparam logic [7:0] CMD_GET_FEAT = 8'hee;
  localparam logic [7:0] UID_ADDR = 8'h00;
  localparam logic [7:0] PROT_ADDR = 8'h00;
  // ==========================================================
  // Device feature map
  localparam logic [7:0] FEAT_ARRAY_MODE = 8'h90;
  localparam logic [7:0] AOM_NORMAL = 8'h08;
  localparam logic [7:0] AOM_OTP = 8'h01;
  localparam logic [7:0] AOM_OTP_PROT = 8'h03;
  localparam logic [31:0] AOM_RESET = 32'h00000008;
  localparam logic [7:0] UID_GOOD = 8'hff;
  localparam int UID_BYTES = 32;
  localparam int UID_HALF = 16;
  localparam int UID_COPIES = 16;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  // ==========================================================
  // Own register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FEAT = 8'h04;
  localparam logic [7:0] REG_PARAM = 8'h08;
  localparam logic [7:0] REG_GETRES = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_CRC = 8'h14;
  localparam logic [7:0] REG_UID0 = 8'h20;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB = 4;
  localparam int CTRL_RESUME_BIT = 7;
  localparam int CTRL_BYTE_LSB = 8;
  localparam int CTRL_KIND_LSB = 16;
  localparam int STAT_DONE_BIT = 1;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int T_WE_LOW_NS = 20;
  localparam int T_RE_LOW_NS = 60;
  localparam int T_HIGH_NS = 20;
  localparam int T_WB_NS = 100;
  localparam logic [7:0] WE_LOW_CYC = 8'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RE_LOW_CYC = 8'((T_RE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HIGH_CYC = 8'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WB_CYC = 8'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    K_CMD = 3'b000, K_ADR = 3'b001, K_WR = 3'b010, K_RD = 3'b011, K_WAIT = 3'b100, K_END = 3'b101
  } nfo_kind_t;
  typedef enum logic [2:0] {
    OP_RAW = 3'b000, OP_SETF = 3'b001, OP_GETF = 3'b010, OP_UID = 3'b011, OP_STAT = 3'b100, OP_PROT = 3'b101
  } nfo_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_FETCH = 3'b001, ST_LOW = 3'b010, ST_HIGH = 3'b011, ST_BUSYW = 3'b100, ST_READYW = 3'b101
  } nfo_state_t;
endpackage

// ### hw/nfo_ctrl.sv
/*
  APB-programmed host controller that drives a parallel NAND device for
  feature set/get, unique ID read with copy validation, status and OTP protect.
  Assumes an asynchronous NAND bus; the bench resolves io from io_oe_n.
*/
`timescale 1ns/100ps
module nfo_ctrl import nfo_pkg::*; #(
  parameter int ADDR_CYCLES = 5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  output logic [7:0] io_o,
  output logic io_oe_n,
  input wire logic [7:0] io_i,
  input wire logic rb_n
);
  // ==========================================================
  // Elaboration checks
  if (ADDR_CYCLES < 1 || ADDR_CYCLES > 5) begin : g_bad_ac
    $error("ADDR_CYCLES must be 1 to 5");
  end
  if (RE_LOW_CYC < 8'h04) begin : g_bad_re
    $error("read strobe too short for input synchroniser");
  end
  // ==========================================================
  // Step decoder
  function automatic logic [10:0] step(input nfo_op_t op, input logic [3:0] i, input logic [7:0] fa,
                                      input logic [31:0] p, input nfo_kind_t rk, input logic [7:0] rb,
                                      input logic rs);
    nfo_kind_t k;
    logic [7:0] b;
    logic [1:0] sel;
    k = K_END;
    b = 8'h00;
    sel = 2'(i - 4'h2);
    case (op)
      OP_RAW: if (i == 4'h0) begin
        k = rk;
        b = rb;
      end
      OP_SETF, OP_PROT: begin
        if (i == 4'h0) begin
          k = K_CMD;
          b = CMD_SET_FEAT;
        end else if (i == 4'h1) begin
          k = K_ADR;
          b = (op == OP_SETF) ? fa : FEAT_ARRAY_MODE;
        end else if (i <= 4'h5) begin
          k = K_WR;
          b = (op == OP_SETF) ? p[{sel, 3'b000} +: 8] : ((i == 4'h2) ? AOM_OTP_PROT : 8'h00);
        end else if (i == 4'h6) begin
          k = K_WAIT;
        end else if (op == OP_PROT) begin
          if (i == 4'h7) begin
            k = K_CMD;
            b = CMD_PROG0;
          end else if (i < 4'(8 + ADDR_CYCLES)) begin
            k = K_ADR;
            b = PROT_ADDR;
          end else if (i == 4'(8 + ADDR_CYCLES)) begin
            k = K_CMD;
            b = CMD_PROG1;
          end else if (i == 4'(9 + ADDR_CYCLES)) begin
            k = K_WAIT;
          end
        end
      end
      OP_GETF: begin
        if (i == 4'h0) begin
          k = K_CMD;
          b = CMD_GET_FEAT;
        end else if (i == 4'h1) begin
          k = K_ADR;
          b = fa;
        end else if (i == 4'h2) begin
          k = K_WAIT;
        end else if (i <= 4'h6) begin
          k = K_RD;
        end
      end
      OP_UID: begin
        if (i == 4'h0) begin
          k = K_CMD;
          b = CMD_UID;
        end else if (i == 4'h1) begin
          k = K_ADR;
          b = UID_ADDR;
        end else if (i == 4'h2) begin
          k = K_WAIT;
        end else if (i == 4'h3) begin
          k = K_RD;
        end
      end
      OP_STAT: begin
        if (i == 4'h0) begin
          k = K_CMD;
          b = CMD_STATUS;
        end else if (i == 4'h1) begin
          k = K_RD;
        end else if (i == 4'h2 && rs) begin
          k = K_CMD;
          b = CMD_READ0;
        end
      end
      default: ;
    endcase
    return {k, b};
  endfunction

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int n = 7; n >= 0; n--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[n]) ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction
  // ==========================================================
  // State
  nfo_state_t state_r, state_nxt;
  nfo_op_t op_r, op_nxt;
  nfo_kind_t kind_r, kind_nxt, raw_kind_r, raw_kind_nxt, fk;
  logic [7:0] fb, cnt_r, cnt_nxt, raw_byte_r, raw_byte_nxt, feat_r, feat_nxt, last_rd_r, last_rd_nxt;
  logic [3:0] idx_r, idx_nxt, copy_r, copy_nxt;
  logic [4:0] ubyte_r, ubyte_nxt;
  logic [31:0] params_r, params_nxt, getres_r, getres_nxt;
  logic [15:0] crc_r, crc_nxt;
  logic resume_r, resume_nxt, done_r, done_nxt, uid_ok_r, uid_ok_nxt, uid_fail_r, uid_fail_nxt;
  logic bad_r, bad_nxt, ce_n_r, ce_n_nxt, cle_r, cle_nxt, ale_r, ale_nxt, we_n_r, we_n_nxt;
  logic re_n_r, re_n_nxt, oe_n_r, oe_n_nxt;
  logic [7:0] io_o_r, io_o_nxt;
  logic [7:0] uid_mem [UID_HALF];
  logic uid_we, rd_cap, wr_acc, rd_acc, hit, bad_now;
  logic [7:0] d, io_s1_r, io_s2_r, io_s3_r, io_lvl_r;
  logic rb_s1_r, rb_s2_r, rb_s3_r, rb_lvl_r, rb_lvl_nxt;
  logic [31:0] rdata;
  logic [10:0] fstep;

  assign pready = en;
  assign wr_acc = psel && penable && pwrite && en;
  assign rd_acc = psel && penable && !pwrite;
  assign d = (io_s2_r == io_s3_r) ? io_s3_r : io_lvl_r;
  assign fstep = step(op_r, idx_r, feat_r, params_r, raw_kind_r, raw_byte_r, resume_r);
  assign fk = nfo_kind_t'(fstep[10:8]);
  assign fb = fstep[7:0];
  assign rd_cap = state_r == ST_LOW && cnt_r == 8'h00 && kind_r == K_RD;
  assign uid_we = rd_cap && op_r == OP_UID && ubyte_r < 5'(UID_HALF);
  assign bad_now = (uid_mem[4'(ubyte_r - 5'(UID_HALF))] ^ d) != UID_GOOD;
  assign rb_lvl_nxt = (rb_s2_r == rb_s3_r) ? rb_s3_r : rb_lvl_r;
  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    kind_nxt = kind_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    raw_kind_nxt = raw_kind_r;
    raw_byte_nxt = raw_byte_r;
    resume_nxt = resume_r;
    feat_nxt = feat_r;
    params_nxt = params_r;
    getres_nxt = getres_r;
    last_rd_nxt = last_rd_r;
    crc_nxt = crc_r;
    done_nxt = done_r;
    uid_ok_nxt = uid_ok_r;
    uid_fail_nxt = uid_fail_r;
    copy_nxt = copy_r;
    ubyte_nxt = ubyte_r;
    bad_nxt = bad_r;
    ce_n_nxt = ce_n_r;
    cle_nxt = cle_r;
    ale_nxt = ale_r;
    we_n_nxt = we_n_r;
    re_n_nxt = re_n_r;
    oe_n_nxt = oe_n_r;
    io_o_nxt = io_o_r;
    if (wr_acc) begin
      case (paddr)
        REG_CTRL: if (state_r == ST_IDLE) begin
          op_nxt = nfo_op_t'(pwdata[CTRL_OP_LSB +: 3]);
          resume_nxt = pwdata[CTRL_RESUME_BIT];
          raw_byte_nxt = pwdata[CTRL_BYTE_LSB +: 8];
          raw_kind_nxt = nfo_kind_t'(pwdata[CTRL_KIND_LSB +: 3]);
          if (pwdata[CTRL_START_BIT]) begin
            state_nxt = ST_FETCH;
            idx_nxt = 4'h0;
            ce_n_nxt = 1'b0;
            uid_ok_nxt = 1'b0;
            uid_fail_nxt = 1'b0;
            copy_nxt = 4'h0;
            ubyte_nxt = 5'h00;
            bad_nxt = 1'b0;
          end
        end
        REG_FEAT: feat_nxt = pwdata[7:0];
        REG_PARAM: params_nxt = pwdata;
        REG_STAT: if (pwdata[STAT_DONE_BIT]) done_nxt = 1'b0;
        REG_CRC: crc_nxt = pwdata[15:0];
        default: ;
      endcase
    end
    case (state_r)
      ST_IDLE: ;
      ST_FETCH: begin
        kind_nxt = fk;
        if (fk == K_END) begin
          state_nxt = ST_IDLE;
          ce_n_nxt = 1'b1;
          done_nxt = 1'b1;
        end else if (fk == K_WAIT) begin
          state_nxt = ST_BUSYW;
          cnt_nxt = WB_CYC - 8'h01;
        end else begin
          state_nxt = ST_LOW;
          cle_nxt = fk == K_CMD;
          ale_nxt = fk == K_ADR;
          oe_n_nxt = fk == K_RD;
          io_o_nxt = fb;
          we_n_nxt = fk == K_RD;
          re_n_nxt = fk != K_RD;
          cnt_nxt = ((fk == K_RD) ? RE_LOW_CYC : WE_LOW_CYC) - 8'h01;
        end
      end
      ST_LOW: if (cnt_r != 8'h00) begin
        cnt_nxt = cnt_r - 8'h01;
      end else begin
        state_nxt = ST_HIGH;
        cnt_nxt = HIGH_CYC - 8'h01;
        we_n_nxt = 1'b1;
        re_n_nxt = 1'b1;
        if (kind_r == K_RD) begin
          last_rd_nxt = d;
          crc_nxt = crc_upd(crc_r, d);
          if (op_r == OP_GETF) getres_nxt = {d, getres_r[31:8]};
          if (op_r == OP_UID) begin
            ubyte_nxt = ubyte_r + 5'h01;
            if (ubyte_r >= 5'(UID_HALF)) bad_nxt = bad_r || bad_now;
            if (ubyte_r == 5'(UID_BYTES - 1)) begin
              bad_nxt = 1'b0;
              if (!(bad_r || bad_now)) uid_ok_nxt = 1'b1;
              else if (copy_r == 4'(UID_COPIES - 1)) uid_fail_nxt = 1'b1;
              else copy_nxt = copy_r + 4'h1;
            end
          end
        end
      end
      ST_HIGH: if (cnt_r != 8'h00) begin
        cnt_nxt = cnt_r - 8'h01;
      end else begin
        state_nxt = ST_FETCH;
        cle_nxt = 1'b0;
        ale_nxt = 1'b0;
        oe_n_nxt = 1'b1;
        if (!(op_r == OP_UID && kind_r == K_RD && !uid_ok_r && !uid_fail_r)) idx_nxt = idx_r + 4'h1;
      end
      ST_BUSYW: if (cnt_r != 8'h00) cnt_nxt = cnt_r - 8'h01;
      else state_nxt = ST_READYW;
      ST_READYW: if (rb_lvl_r) begin
        state_nxt = ST_FETCH;
        idx_nxt = idx_r + 4'h1;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      op_r <= OP_RAW;
      kind_r <= K_END;
      raw_kind_r <= K_CMD;
      idx_r <= 4'h0;
      cnt_r <= 8'h00;
      raw_byte_r <= 8'h00;
      resume_r <= 1'b0;
      feat_r <= FEAT_ARRAY_MODE;
      params_r <= AOM_RESET;
      getres_r <= 32'h00000000;
      last_rd_r <= 8'h00;
      crc_r <= CRC_RESET;
      done_r <= 1'b0;
      uid_ok_r <= 1'b0;
      uid_fail_r <= 1'b0;
      copy_r <= 4'h0;
      ubyte_r <= 5'h00;
      bad_r <= 1'b0;
      ce_n_r <= 1'b1;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
      we_n_r <= 1'b1;
      re_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      io_o_r <= 8'h00;
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
      io_s3_r <= 8'h00;
      io_lvl_r <= 8'h00;
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
      rb_s3_r <= 1'b1;
      rb_lvl_r <= 1'b1;
    end else if (en) begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      kind_r <= kind_nxt;
      raw_kind_r <= raw_kind_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      raw_byte_r <= raw_byte_nxt;
      resume_r <= resume_nxt;
      feat_r <= feat_nxt;
      params_r <= params_nxt;
      getres_r <= getres_nxt;
      last_rd_r <= last_rd_nxt;
      crc_r <= crc_nxt;
      done_r <= done_nxt;
      uid_ok_r <= uid_ok_nxt;
      uid_fail_r <= uid_fail_nxt;
      copy_r <= copy_nxt;
      ubyte_r <= ubyte_nxt;
      bad_r <= bad_nxt;
      ce_n_r <= ce_n_nxt;
      cle_r <= cle_nxt;
      ale_r <= ale_nxt;
      we_n_r <= we_n_nxt;
      re_n_r <= re_n_nxt;
      oe_n_r <= oe_n_nxt;
      io_o_r <= io_o_nxt;
      io_s1_r <= io_i;
      io_s2_r <= io_s1_r;
      io_s3_r <= io_s2_r;
      io_lvl_r <= d;
      rb_s1_r <= rb_n;
      rb_s2_r <= rb_s1_r;
      rb_s3_r <= rb_s2_r;
      rb_lvl_r <= rb_lvl_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (en && uid_we) uid_mem[ubyte_r[3:0]] <= d;
  end
  // ==========================================================
  // Register read and pins
  always_comb begin
    hit = 1'b1;
    rdata = 32'h00000000;
    case (paddr)
      REG_CTRL: rdata = {13'h0000, raw_kind_r, raw_byte_r, resume_r, op_r, 3'b000, state_r != ST_IDLE};
      REG_FEAT: rdata = {24'h000000, feat_r};
      REG_PARAM: rdata = params_r;
      REG_GETRES: rdata = getres_r;
      REG_STAT: rdata = {8'h00, last_rd_r, 4'h0, copy_r, 3'b000, rb_lvl_r, uid_fail_r, uid_ok_r, done_r,
                         state_r != ST_IDLE};
      REG_CRC: rdata = {16'h0000, crc_r};
      REG_UID0, REG_UID0 + 8'h04, REG_UID0 + 8'h08, REG_UID0 + 8'h0c:
        rdata = {uid_mem[{paddr[3:2], 2'b11}], uid_mem[{paddr[3:2], 2'b10}], uid_mem[{paddr[3:2], 2'b01}],
                 uid_mem[{paddr[3:2], 2'b00}]};
      default: hit = 1'b0;
    endcase
  end

  assign prdata = rd_acc ? rdata : 32'h00000000;
  assign pslverr = psel && penable && !hit;
  assign ce_n = ce_n_r;
  assign cle = cle_r;
  assign ale = ale_r;
  assign we_n = we_n_r;
  assign re_n = re_n_r;
  assign wp_n = 1'b1;
  assign io_o = io_o_r;
  assign io_oe_n = oe_n_r;
  // ==========================================================
  // Assertions
  sequence fetch_s(nfo_op_t o, logic [3:0] n);
    en && state_r == ST_FETCH && op_r == o && idx_r == n;
  endsequence

  uid_cmd_a: assert property (@(posedge clk) disable iff (!arst_n)
    fetch_s(OP_UID, 4'h0) |=> cle && !ale && io_o == CMD_UID && !io_oe_n) else $error("uid command wrong");
  uid_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
    fetch_s(OP_UID, 4'h1) |=> ale && !cle && io_o == UID_ADDR) else $error("uid address wrong");
  uid_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(uid_fail_r) |-> copy_r == 4'(UID_COPIES - 1) && !uid_ok_r) else $error("uid fail before last copy");
  setf_param_a: assert property (@(posedge clk) disable iff (!arst_n)
    fetch_s(OP_SETF, 4'h2) |=> io_o == params_r[7:0] && !io_oe_n && !we_n) else $error("param byte wrong");
  getf_cmd_a: assert property (@(posedge clk) disable iff (!arst_n)
    fetch_s(OP_GETF, 4'h0) |=> cle && io_o == CMD_GET_FEAT) else $error("get feature command wrong");
  stat_resume_a: assert property (@(posedge clk) disable iff (!arst_n)
    fetch_s(OP_STAT, 4'h2) ##0 resume_r |=> cle && io_o == CMD_READ0) else $error("no read resume after status");
  prot_prog_a: assert property (@(posedge clk) disable iff (!arst_n)
    fetch_s(OP_PROT, 4'h7) |=> cle && io_o == CMD_PROG0) else $error("protect program command wrong");
  ready_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    en && state_r == ST_READYW && !rb_lvl_r |=> state_r == ST_READYW) else $error("left busy wait early");
  strobe_excl_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(!we_n && !re_n) && !(cle && ale)) else $error("strobes overlap");
endmodule

// ### test/nfo_nand_model.sv
/*
  Behavioural model of the NAND device on the far side of the controller.
  Assumes the controller's strobes; released data shows the inverse of the last byte.
*/
`timescale 1ns/100ps
module nfo_nand_model import nfo_pkg::*; (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output logic rb_n
);
  // ==========================================================
  // Device state
  logic [31:0] aom;
  logic [31:0] pbuf;
  logic [7:0] mode, prev_mode, fadr, last_cmd;
  logic prot, spoil;
  int acnt, pcnt, rcnt;
  initial begin
    aom = AOM_RESET;
    rb_n = 1'b1;
    dout = 8'h5a;
    prot = 1'b0;
    spoil = 1'b0;
    mode = 8'h00;
  end
  function automatic logic [7:0] uid_byte(int n);
    int c, i;
    logic [7:0] b;
    c = (n / 32) % 16;
    i = n % 32;
    b = 8'(c * 16 + (i % 16) + 49);
    if (i >= 16) b = ~b ^ (((c == 0 || spoil) && i == 16) ? 8'h01 : 8'h00);
    return b;
  endfunction
  task automatic busy(int ns);
    rb_n = 1'b0;
    #(ns);
    rb_n = 1'b1;
  endtask
  // ==========================================================
  // Write cycles
  always @(posedge we_n) begin
    if (!ce_n) begin
      if (cle) begin
        last_cmd = din;
        acnt = 0;
        pcnt = 0;
        if (din == CMD_STATUS) begin
          prev_mode = mode;
          mode = din;
        end else if (din == CMD_READ0 && mode == CMD_STATUS) begin
          mode = prev_mode;
        end else if (din == CMD_PROG1) begin
          if (mode == CMD_PROG0 && aom[7:0] == AOM_OTP_PROT) prot = 1'b1;
          fork busy(500); join_none
        end else if (din != 8'hff) begin
          mode = din;
          rcnt = 0;
        end
      end else if (ale) begin
        if (acnt == 0) fadr = din;
        acnt++;
        if (mode == CMD_GET_FEAT || mode == CMD_UID) fork busy(200); join_none
      end else if (mode == CMD_SET_FEAT && pcnt < 4) begin
        pbuf[8*pcnt+:8] = din;
        pcnt++;
        if (pcnt == 4) begin
          if (fadr == FEAT_ARRAY_MODE) aom = pbuf;
          fork busy(300); join_none
        end
      end
    end
  end
  // ==========================================================
  // Read cycles
  always @(negedge re_n) begin
    if (!ce_n) begin
      if (mode == CMD_STATUS) dout = {1'b1, rb_n, 6'h00};
      else if (mode == CMD_GET_FEAT) dout = (fadr == FEAT_ARRAY_MODE) ? aom[8*(rcnt%4)+:8] : 8'h00;
      else if (mode == CMD_UID) dout = uid_byte(rcnt);
      else dout = 8'h00;
      if (mode != CMD_STATUS) rcnt++;
    end
  end
  always @(posedge re_n) dout = ~dout;
endmodule

// ### test/tb_top.sv
/*
  Self-checking bench for the NAND host controller, driven over APB.
  Assumes the device model answers on the NAND pins.
*/
`timescale 1ns/100ps
module tb_top import nfo_pkg::*;;
  // ==========================================================
  // Signals
  logic clk = 1'b0, arst_n = 1'b0, en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, last_err, ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n, rb_n;
  logic [7:0] io_o, dq, io_i;
  int mismatches = 0, check_count = 0, cycles = 0;
  assign io_i = io_oe_n ? dq : io_o;
  always #5 clk = ~clk;
  nfo_ctrl dut (.clk(clk), .arst_n(arst_n), .en(en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
    .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_o(io_o), .io_oe_n(io_oe_n),
    .io_i(io_i), .rb_n(rb_n));
  nfo_nand_model nand_dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .din(io_o),
    .dout(dq), .rb_n(rb_n));
  // ==========================================================
  // Tasks
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      end_sim;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask
  task automatic run_op(input logic [2:0] op, input logic resume, input logic [7:0] b);
    logic [31:0] s;
    int n;
    wr(REG_CTRL, (32'(resume) << CTRL_RESUME_BIT) | (32'(b) << CTRL_BYTE_LSB) | (32'(op) << CTRL_OP_LSB) | 32'h1);
    n = 0;
    do begin
      rd(REG_STAT, s);
      n++;
    end while (s[STAT_DONE_BIT] !== 1'b1 && n < 3000);
    check(32'(s[STAT_DONE_BIT]), 32'h1, "operation did not finish");
    wr(REG_STAT, 32'h2);
  endtask
  task automatic getf(input logic [7:0] fa, input logic [31:0] exp);
    logic [31:0] r;
    wr(REG_FEAT, 32'(fa));
    run_op(OP_GETF, 1'b0, 8'h00);
    rd(REG_GETRES, r);
    check(r, exp, "feature parameters");
  endtask
  task automatic setf(input logic [7:0] fa, input logic [31:0] p);
    wr(REG_FEAT, 32'(fa));
    wr(REG_PARAM, p);
    run_op(OP_SETF, 1'b0, 8'h00);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] r;
    rd(REG_FEAT, r);
    check(r, 32'h90, "feature address reset");
    rd(REG_PARAM, r);
    check(r, AOM_RESET, "parameter reset");
    rd(REG_CRC, r);
    check(r, 32'h0, "crc reset");
    check(32'(wp_n), 32'h1, "write protect released");
    rd(8'h40, r);
    check(32'(last_err), 32'h1, "unmapped access");
  endtask
  task automatic t_feature;
    getf(FEAT_ARRAY_MODE, AOM_RESET);
    check(32'(nand_dev.last_cmd), 32'(CMD_GET_FEAT), "get command");
    setf(FEAT_ARRAY_MODE, 32'(AOM_OTP));
    check(nand_dev.aom, 32'h1, "otp mode entered");
    run_op(OP_RAW, 1'b0, 8'hff);
    getf(FEAT_ARRAY_MODE, 32'h1);
    setf(8'h91, 32'h3);
    getf(8'h91, 32'h0);
    getf(FEAT_ARRAY_MODE, 32'h1);
    setf(FEAT_ARRAY_MODE, 32'(AOM_NORMAL));
    getf(FEAT_ARRAY_MODE, 32'h8);
  endtask
  task automatic t_uid;
    logic [31:0] r;
    logic [15:0] crc;
    logic [7:0] b;
    crc = 16'h0;
    wr(REG_CRC, 32'h0);
    run_op(OP_UID, 1'b0, 8'h00);
    for (int n = 0; n < 64; n++) begin
      b = 8'(((n / 32) * 16) + (n % 16) + 49);
      if ((n % 32) >= 16) b = ~b ^ ((n == 16) ? 8'h01 : 8'h00);
      crc = crc ^ {b, 8'h00};
      for (int k = 0; k < 8; k++) crc = crc[15] ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
    end
    rd(REG_STAT, r);
    check({28'h0, r[3:2]}, 32'h1, "copy validation");
    check(32'(r[11:8]), 32'h1, "good copy index");
    for (int w = 0; w < 4; w++) begin
      rd(8'(REG_UID0 + 4 * w), r);
      for (int k = 0; k < 4; k++) check(32'(r[8*k+:8]), 32'(16 + 4 * w + k + 49), "identifier byte");
    end
    rd(REG_CRC, r);
    check(r, 32'(crc), "crc over read bytes");
    nand_dev.spoil = 1'b1;
    run_op(OP_UID, 1'b0, 8'h00);
    nand_dev.spoil = 1'b0;
    rd(REG_STAT, r);
    check({28'h0, r[3:2]}, 32'h2, "all copies rejected");
    check(32'(r[11:8]), 32'(UID_COPIES - 1), "last copy index");
  endtask
  task automatic t_hold;
    logic [31:0] r;
    logic [7:0] f;
    int n;
    wr(REG_CTRL, (32'(OP_STAT) << CTRL_OP_LSB) | 32'h1);
    repeat (3) @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    f = {ce_n, cle, ale, we_n, re_n, io_oe_n, 2'b00};
    repeat (20) @(posedge clk);
    check(32'(ce_n), 32'h0, "operation in progress");
    check(32'({ce_n, cle, ale, we_n, re_n, io_oe_n, 2'b00}), 32'(f), "pins frozen while disabled");
    check(32'(pready), 32'h0, "no ready while disabled");
    en <= 1'b1;
    n = 0;
    do begin
      rd(REG_STAT, r);
      n++;
    end while (r[STAT_DONE_BIT] !== 1'b1 && n < 3000);
    check(32'(r[23:16]), 32'hc0, "status after enable returns");
    wr(REG_STAT, 32'h2);
  endtask
  task automatic t_status;
    logic [31:0] r;
    run_op(OP_STAT, 1'b1, 8'h00);
    rd(REG_STAT, r);
    check(32'(r[23:16]), 32'hc0, "status byte");
    check(32'(nand_dev.last_cmd), 32'(CMD_READ0), "resume command");
    check(32'(nand_dev.mode), 32'(CMD_UID), "identifier mode kept");
  endtask
  task automatic t_prot;
    run_op(OP_PROT, 1'b0, 8'h00);
    check(32'(nand_dev.last_cmd), 32'(CMD_PROG1), "protect confirm");
    check(32'(nand_dev.prot), 32'h1, "area protected");
    setf(FEAT_ARRAY_MODE, 32'(AOM_NORMAL));
    check(nand_dev.aom, 32'h8, "protect mode left");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_feature;
    t_uid;
    t_status;
    t_hold;
    t_prot;
    end_sim;
  end
endmodule
